// File: wdt_pkg.sv
// Constants, register map and types for the window-mode watchdog timer
package wdt_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int RC_CLK_HZ = 32_000;
  localparam int RC_CLK_DIV = CLK_HZ / RC_CLK_HZ;
  localparam int PRE_SMALL = 32;
  localparam int PRE_LARGE = 128;
  localparam int PRE_SMALL_LOG2 = 5;
  localparam int PRE_LARGE_LOG2 = 7;
  localparam int BASE_SMALL_US = 1000;
  localparam int BASE_LARGE_US = 4000;
  localparam int BASE_SMALL_TICKS = BASE_SMALL_US * RC_CLK_HZ / 1_000_000;
  localparam int CNT_W = 22;
  localparam int PER_W = 23;
  localparam int DIV_W = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RESET_CTRL = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_PRE_BIT = 4;
  localparam int CFG_WINDOW_DIS_BIT = 6;
  localparam int CFG_PERM_BIT = 7;
  localparam logic [3:0] CFG_POST_RST = 4'hF;
  localparam logic CFG_PRE_RST = 1'h1;
  localparam logic CFG_WINDOW_DIS_RST = 1'h1;
  localparam logic CFG_PERM_RST = 1'h0;
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_TIMEOUT_BIT = 4;
  localparam int RC_SWEN_BIT = 5;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CMD_IDLE_BIT = 2;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_EARLY = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_W = 3;

  typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE} pwr_state_t;
endpackage

// File: watchdog_timer.sv
// Watchdog timer with window mode, power-save wake and AHB-Lite registers
//
// Operation
// R1 - Runs from low-power RC; enable starts it
// R2 - Prescaler divides by 32 or 128
// R3 - Base period 1 ms or 4 ms
// R4 - 4-bit postscaler, sixteen power-of-two ratios
// R5 - Clear on reset, switch, power-save, clear
// R6 - Counts in sleep/idle; time-out wakes core
// R7 - Software clears sleep and idle flags
// R8 - Time-out flag sticky until software clears
// R9 - Permanent enable forces watchdog running
// R10 - Otherwise software enable bit gates running
// R11 - Device reset clears software enable
// R12 - Window mode: early clear causes reset
// R13 - Permanent enable ignores software enable clears
// R14 - Code 1111 gives 1:32768, halving downward
// R15 - Run-mode time-out resets device, sets flag
// R16 - Non-window clear accepted any time in run state, restarts period
`timescale 1ns/100ps
module watchdog_timer #(
  parameter int RC_DIV_CYC = wdt_pkg::RC_CLK_DIV
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // System events
  input wire logic i_device_reset,
  input wire logic i_clock_switch_done,
  input wire logic i_wake_other,
  // Watchdog outputs
  output logic o_wdt_reset,
  output logic o_wake,
  output logic o_rc_clock_enable,
  output logic o_irq
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'h0;
      rst_n_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Period arithmetic
  // ----------------------------------------------------------------
  // Prescale and postscale fold into one tick counter of 2^(p+q) ticks
  function automatic logic [PER_W-1:0] period_ticks(input logic pre, input logic [3:0] post);
    logic [4:0] sh;
    sh = {1'b0, post} + (pre ? 5'(PRE_LARGE_LOG2) : 5'(PRE_SMALL_LOG2));
    period_ticks = PER_W'(1) << sh;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic dph_ff, nxt_dph;
  logic perm_ff, nxt_perm;
  logic window_dis_ff, nxt_window_dis;
  logic pre_ff, nxt_pre;
  logic [3:0] post_ff, nxt_post;
  logic swen_ff, nxt_swen;
  logic timeout_flag_ff, nxt_timeout_flag;
  logic sleepf_ff, nxt_sleepf;
  logic idlef_ff, nxt_idlef;
  logic [EV_W-1:0] sts_ff, nxt_sts;
  logic [EV_W-1:0] mask_ff, nxt_mask;
  pwr_state_t state_ff, nxt_state;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic wdt_rst_ff, nxt_wdt_rst;
  logic wake_ff, nxt_wake;
  logic irq_ff, nxt_irq;
  logic rc_en_ff, nxt_rc_en;
  logic [31:0] hrdata_ff, nxt_hrdata;

  logic [PER_W-1:0] period;
  logic enabled, tick, timeout, win_open, early, dev_rst;
  logic wr_cfg, wr_rc, wr_cmd, wr_sts, wr_mask;
  logic clr_cmd, sleep_cmd, idle_cmd, entry, wake_exit;
  logic [EV_W-1:0] ev;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wr = wr_ff;
    nxt_dph = 1'h0;
    nxt_perm = perm_ff;
    nxt_window_dis = window_dis_ff;
    nxt_pre = pre_ff;
    nxt_post = post_ff;
    nxt_swen = swen_ff;
    nxt_timeout_flag = timeout_flag_ff;
    nxt_sleepf = sleepf_ff;
    nxt_idlef = idlef_ff;
    nxt_mask = mask_ff;
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_cnt = cnt_ff;
    nxt_hrdata = hrdata_ff;

    // Bus data-phase decode
    wr_cfg = dph_ff && wr_ff && (addr_ff == OFS_CONFIG);
    wr_rc = dph_ff && wr_ff && (addr_ff == OFS_RESET_CTRL);
    wr_cmd = dph_ff && wr_ff && (addr_ff == OFS_COMMAND);
    wr_sts = dph_ff && wr_ff && (addr_ff == OFS_IRQ_STATUS);
    wr_mask = dph_ff && wr_ff && (addr_ff == OFS_IRQ_MASK);
    clr_cmd = wr_cmd && i_hwdata[CMD_CLEAR_BIT] && (state_ff == PS_RUN);
    sleep_cmd = wr_cmd && i_hwdata[CMD_SLEEP_BIT] && (state_ff == PS_RUN);
    idle_cmd = wr_cmd && i_hwdata[CMD_IDLE_BIT] && (state_ff == PS_RUN) && !sleep_cmd;
    entry = sleep_cmd || idle_cmd;

    // R9 permanent enable
    // R10 software enable gate
    enabled = perm_ff || swen_ff;
    // R2 prescale select
    // R4 postscale ratio
    // R14 code to ratio
    period = period_ticks(pre_ff, post_ff);
    // R1 RC tick enable
    // R3 tick rate 32 kHz
    tick = enabled && (div_ff == DIV_W'(RC_DIV_CYC - 1));
    timeout = tick && ({1'b0, cnt_ff} == period - PER_W'(1));
    // R12 last quarter window
    win_open = {1'b0, cnt_ff} >= period - (period >> 2);
    early = clr_cmd && !window_dis_ff && !win_open && enabled;
    // R6 time-out or other event wakes
    wake_exit = (state_ff != PS_RUN) && (timeout || i_wake_other);
    dev_rst = i_device_reset || wdt_rst_ff;

    // R1 RC divider runs only when enabled
    if (!enabled || dev_rst || div_ff == DIV_W'(RC_DIV_CYC - 1)) begin
      nxt_div = '0;
    end else begin
      nxt_div = div_ff + DIV_W'(1);
    end

    // R5 count clear sources
    // R16 clear restarts period
    if (dev_rst || !enabled || i_clock_switch_done || clr_cmd || entry || wake_exit ||
        timeout) begin
      nxt_cnt = '0;
    end else if (tick) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end

    // R6 power-save states
    unique case (state_ff)
      PS_RUN: begin
        if (sleep_cmd) begin
          nxt_state = PS_SLEEP;
        end else if (idle_cmd) begin
          nxt_state = PS_IDLE;
        end
      end
      PS_SLEEP, PS_IDLE: begin
        if (wake_exit) begin
          nxt_state = PS_RUN;
        end
      end
    endcase
    if (dev_rst) begin
      nxt_state = PS_RUN;
    end

    // R15 run-mode time-out resets
    // R12 early clear resets
    nxt_wdt_rst = (timeout && state_ff == PS_RUN) || early;
    nxt_wake = timeout && (state_ff != PS_RUN);

    // R8 sticky flag, set wins over clear
    nxt_timeout_flag = (timeout_flag_ff && !(wr_rc && i_hwdata[RC_TIMEOUT_BIT])) || timeout ||
                       early;
    // R7 flags left for software to clear
    nxt_sleepf = (sleepf_ff && !(wr_rc && i_hwdata[RC_SLEEP_BIT])) || sleep_cmd;
    nxt_idlef = (idlef_ff && !(wr_rc && i_hwdata[RC_IDLE_BIT])) || idle_cmd;

    // R13 clears ignored when permanent
    if (wr_rc && (i_hwdata[RC_SWEN_BIT] || !perm_ff)) begin
      nxt_swen = i_hwdata[RC_SWEN_BIT];
    end
    // R11 reset clears software enable
    if (dev_rst) begin
      nxt_swen = 1'h0;
    end

    if (wr_cfg) begin
      nxt_post = i_hwdata[CFG_POST_LSB +: 4];
      nxt_pre = i_hwdata[CFG_PRE_BIT];
      nxt_window_dis = i_hwdata[CFG_WINDOW_DIS_BIT];
      nxt_perm = i_hwdata[CFG_PERM_BIT];
    end
    if (wr_mask) begin
      nxt_mask = i_hwdata[EV_W-1:0];
    end

    // Interrupt events, set wins over write-one clear
    ev = '0;
    ev[EV_TIMEOUT] = timeout;
    ev[EV_EARLY] = early;
    ev[EV_WAKE] = wake_exit;
    nxt_sts = (sts_ff & ~(wr_sts ? i_hwdata[EV_W-1:0] : {EV_W{1'b0}})) | ev;
    nxt_irq = |(sts_ff & mask_ff);
    nxt_rc_en = enabled;

    // Address phase capture and read data
    if (i_hsel && i_htrans[1] && i_hready) begin
      nxt_addr = {i_haddr[7:2], 2'b00};
      nxt_wr = i_hwrite;
      nxt_dph = 1'h1;
      nxt_hrdata = '0;
      if (!i_hwrite) begin
        unique case ({i_haddr[7:2], 2'b00})
          OFS_CONFIG: begin
            nxt_hrdata[CFG_POST_LSB +: 4] = post_ff;
            nxt_hrdata[CFG_PRE_BIT] = pre_ff;
            nxt_hrdata[CFG_WINDOW_DIS_BIT] = window_dis_ff;
            nxt_hrdata[CFG_PERM_BIT] = perm_ff;
          end
          OFS_RESET_CTRL: begin
            nxt_hrdata[RC_IDLE_BIT] = idlef_ff;
            nxt_hrdata[RC_SLEEP_BIT] = sleepf_ff;
            nxt_hrdata[RC_TIMEOUT_BIT] = timeout_flag_ff;
            nxt_hrdata[RC_SWEN_BIT] = swen_ff;
          end
          OFS_IRQ_STATUS: nxt_hrdata[EV_W-1:0] = sts_ff;
          OFS_IRQ_MASK: nxt_hrdata[EV_W-1:0] = mask_ff;
          OFS_COUNT: nxt_hrdata[CNT_W-1:0] = cnt_ff;
          default: nxt_hrdata = '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Flags survive the watchdog's own reset so software can see the cause
  always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_ff <= 8'h00;
      wr_ff <= 1'h0;
      dph_ff <= 1'h0;
      perm_ff <= CFG_PERM_RST;
      window_dis_ff <= CFG_WINDOW_DIS_RST;
      pre_ff <= CFG_PRE_RST;
      post_ff <= CFG_POST_RST;
      swen_ff <= 1'h0;
      timeout_flag_ff <= 1'h0;
      sleepf_ff <= 1'h0;
      idlef_ff <= 1'h0;
      sts_ff <= '0;
      mask_ff <= '0;
      state_ff <= PS_RUN;
      div_ff <= '0;
      cnt_ff <= '0;
      wdt_rst_ff <= 1'h0;
      wake_ff <= 1'h0;
      irq_ff <= 1'h0;
      rc_en_ff <= 1'h0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      dph_ff <= nxt_dph;
      perm_ff <= nxt_perm;
      window_dis_ff <= nxt_window_dis;
      pre_ff <= nxt_pre;
      post_ff <= nxt_post;
      swen_ff <= nxt_swen;
      timeout_flag_ff <= nxt_timeout_flag;
      sleepf_ff <= nxt_sleepf;
      idlef_ff <= nxt_idlef;
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      wdt_rst_ff <= nxt_wdt_rst;
      wake_ff <= nxt_wake;
      irq_ff <= nxt_irq;
      rc_en_ff <= nxt_rc_en;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states: every transfer completes OKAY in one data phase
  assign o_hrdata = hrdata_ff;
  assign o_hreadyout = rst_n_ff;
  assign o_hresp = 1'h0;
  assign o_wdt_reset = wdt_rst_ff;
  assign o_wake = wake_ff;
  assign o_rc_clock_enable = rc_en_ff;
  assign o_irq = irq_ff;
endmodule

// File: watchdog_timer_asserts.sv
// Concurrent checks on the watchdog ports
`timescale 1ns/100ps
module watchdog_timer_checker #(
  parameter int RC_DIV_CYC = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Watchdog
  input wire logic o_wdt_reset,
  input wire logic o_wake,
  input wire logic o_rc_clock_enable,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("bus error response seen");
  a_ready_stays: assert property ($past(o_hreadyout) |-> o_hreadyout)
    else $error("ready dropped");
  a_reset_pulse_one: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("reset pulse too long");
  a_wake_pulse_one: assert property (o_wake |=> !o_wake)
    else $error("wake pulse too long");
  a_pulses_apart: assert property (!(o_wdt_reset && o_wake))
    else $error("reset and wake together");
  a_wake_needs_run: assert property (o_wake |-> $past(o_rc_clock_enable))
    else $error("wake while stopped");
  a_reset_needs_run: assert property (o_wdt_reset |-> $past(o_rc_clock_enable))
    else $error("reset while stopped");
  a_wake_keeps_run: assert property (o_wake |=> o_rc_clock_enable)
    else $error("watchdog stopped by wake");
  a_unmapped_zero: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
    && i_haddr[7:2] > 6'h05 |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  c_reset: cover property (o_wdt_reset);
  c_wake: cover property (o_wake);
  c_irq: cover property ($rose(o_irq));
endmodule

bind watchdog_timer watchdog_timer_checker #(.RC_DIV_CYC(RC_DIV_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_wdt_reset(o_wdt_reset),
  .o_wake(o_wake), .o_rc_clock_enable(o_rc_clock_enable), .o_irq(o_irq));

// File: watchdog_timer_window_mode_tb.sv
// Self-checking bench for the window-mode watchdog
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module watchdog_timer_window_mode_tb;
  import wdt_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, wr_en = 0, dev_rst = 0, sw_done = 0, wake_oth = 0;
  logic [31:0] addr = 0, wdata = 0, rdata, r;
  logic [1:0] trans = 0;
  logic hrdy, resp, wdt_rst, wake, rc_en, irq;
  int n_fail = 0, total_checks = 0, n_rst = 0, n_wake = 0, cyc = 0;

  // Short tick divider keeps periods to a few hundred cycles
  watchdog_timer #(.RC_DIV_CYC(4)) dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_hsel(sel), .i_haddr(addr),
    .i_htrans(trans), .i_hwrite(wr_en), .i_hsize(3'h2), .i_hwdata(wdata),
    .i_hready(hrdy), .o_hrdata(rdata), .o_hreadyout(hrdy), .o_hresp(resp),
    .i_device_reset(dev_rst), .i_clock_switch_done(sw_done), .i_wake_other(wake_oth),
    .o_wdt_reset(wdt_rst), .o_wake(wake), .o_rc_clock_enable(rc_en), .o_irq(irq));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt_rst === 1'b1) n_rst <= n_rst + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (cyc == 10000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ------------------------------------------------
  // Bus tasks
  // ------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    addr <= {24'h0, a};
    trans <= 2'h2;
    wr_en <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    trans <= 2'h0;
    wdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string n);
    xfer(a, 1'b0, 32'h0);
    `CHK(n, e, r & m)
  endtask
  task automatic run(input logic [31:0] cfg, input int p);
    int b;
    b = n_rst;
    xfer(OFS_CONFIG, 1'b1, cfg);
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    repeat (4 * p - 8) @(posedge clk);
    `CHK("early", b, n_rst)
    repeat (16) @(posedge clk);
    `CHK("timeout", b + 1, n_rst)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    int b;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CONFIG, 32'hFF, 32'h5F, "config"); // defaults
    rd(OFS_RESET_CTRL, 32'hFFFFFFFF, 32'h0, "rctl"); // enable clear
    rd(8'h3C, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test reset done");
    run(32'h40, 32); // divide by 32
    run(32'h41, 64); // ratio two
    run(32'h42, 128); // ratio four
    run(32'h50, 128); // divide by 128
    rd(OFS_RESET_CTRL, 32'h30, 32'h10, "flag"); // sticky flag
    rd(OFS_IRQ_STATUS, 32'h1, 32'h1, "event"); // event bit
    xfer(OFS_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq) // unmasked event
    xfer(OFS_IRQ_STATUS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq) // cleared event
    xfer(OFS_RESET_CTRL, 1'b1, 32'h10);
    rd(OFS_RESET_CTRL, 32'h10, 32'h0, "wclr"); // software clear
    $display("test period done");
    // Clear, clock switch and device reset all restart or stop the count
    b = n_rst;
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    repeat (2) @(posedge clk);
    `CHK("rc_en", 1'b1, rc_en) // enable starts clock
    // Each gap is over half the period, so a missed restart times out
    repeat (300) @(posedge clk);
    xfer(OFS_COMMAND, 1'b1, 32'h1);
    repeat (300) @(posedge clk);
    sw_done <= 1'b1;
    @(posedge clk);
    sw_done <= 1'b0;
    repeat (300) @(posedge clk);
    `CHK("restart", b, n_rst) // no time-out
    dev_rst <= 1'b1;
    @(posedge clk);
    dev_rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("devrst", 1'b0, rc_en) // enable cleared
    $display("test restart done");
    xfer(OFS_CONFIG, 1'b1, 32'h0);
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    b = n_rst;
    repeat (4) @(posedge clk);
    xfer(OFS_COMMAND, 1'b1, 32'h1);
    repeat (4) @(posedge clk);
    `CHK("early clr", b + 1, n_rst) // early clear resets
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    repeat (108) @(posedge clk);
    b = n_rst;
    xfer(OFS_COMMAND, 1'b1, 32'h1);
    repeat (4) @(posedge clk);
    `CHK("late clr", b, n_rst) // clear inside window
    xfer(OFS_RESET_CTRL, 1'b1, 32'h0);
    rd(OFS_IRQ_STATUS, 32'h2, 32'h2, "early ev"); // event bit
    $display("test window done");
    xfer(OFS_CONFIG, 1'b1, 32'h40);
    for (int k = 1; k < 3; k++) begin
      b = n_wake;
      xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
      xfer(OFS_COMMAND, 1'b1, 32'h1 << k);
      repeat (140) @(posedge clk);
      `CHK("wake", b + 1, n_wake) // time-out wakes core
      rd(OFS_RESET_CTRL, 32'h1 << (4 - k), 32'h1 << (4 - k), "psflag"); // flag kept
      // software clears sleep and idle flags
      xfer(OFS_RESET_CTRL, 1'b1, 32'h0C);
    end
    // Another wake source ends idle and restarts the count
    b = n_wake;
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    xfer(OFS_COMMAND, 1'b1, 32'h4);
    repeat (60) @(posedge clk);
    wake_oth <= 1'b1;
    @(posedge clk);
    wake_oth <= 1'b0;
    rd(OFS_COUNT, 32'h3FFFFE, 32'h0, "exit clr"); // exit clears count
    `CHK("other wake", b, n_wake) // no time-out pulse
    xfer(OFS_RESET_CTRL, 1'b1, 32'h0C);
    $display("test power save done");
    // Permanent enable ignores a software stop
    xfer(OFS_CONFIG, 1'b1, 32'hC0);
    xfer(OFS_RESET_CTRL, 1'b1, 32'h20);
    xfer(OFS_RESET_CTRL, 1'b1, 32'h0);
    b = n_rst;
    repeat (2) @(posedge clk);
    `CHK("perm", 1'b1, rc_en) // clock stays on
    rd(OFS_RESET_CTRL, 32'h20, 32'h20, "perm swen"); // stop write ignored
    repeat (140) @(posedge clk);
    `CHK("perm rst", b + 1, n_rst) // always running
    xfer(OFS_CONFIG, 1'b1, 32'h40);
    repeat (2) @(posedge clk);
    `CHK("soft", 1'b0, rc_en) // software gate
    $display("test permanent done");
    give_verdict();
  end
endmodule
